// ---- rtl/bvw_consts.vh ----
// Purpose: constants shared by the self-test, pad voltage and watchdog register block
// Assumes: 25 MHz pclk, APB with 32-bit data, one aligned word per register
// Notes: register offsets are word indices, byte address is four times the index
`ifndef BVW_CONSTS_VH
`define BVW_CONSTS_VH

// ****************************************
// register indices and address width
// ****************************************
`define BVW_IDX_SELFTEST 8'h14
`define BVW_IDX_PADVSEL 8'h15
`define BVW_IDX_WDOG 8'h16
`define BVW_IDX_IRQ_STATUS 8'h20
`define BVW_IDX_IRQ_MASK 8'h21
`define BVW_ADDR_W 10

// ****************************************
// field positions
// ****************************************
`define BVW_ST_EN_BIT 0
`define BVW_ST_OSC_LO 1
`define BVW_ST_OSC_HI 2
`define BVW_WD_DIS_BIT 0
`define BVW_WD_TMO_LO 1
`define BVW_WD_TMO_HI 7
`define BVW_IRQ_WDOG_BIT 0
`define BVW_IRQ_VRST_BIT 1
`define BVW_IRQ_W 2

// ****************************************
// reset values and write codes
// ****************************************
`define BVW_RST_SELFTEST 8'h00
`define BVW_RST_PADVSEL 1'b1
`define BVW_RST_WDOG 8'hfe
`define BVW_VSEL_SET_CODE 8'hb5
`define BVW_VSEL_CLR_CODE 8'hb6

// ****************************************
// framing clock selection codes
// ****************************************
`define BVW_CLK_TMDS 3'h0
`define BVW_CLK_OSC50 3'h1
`define BVW_CLK_OSC100 3'h2
`define BVW_CLK_OSC25 3'h3
`define BVW_CLK_OSC33 3'h4
`define BVW_CLK_EXTPIX 3'h5

// ****************************************
// timing
// ****************************************
`define BVW_CLK_PERIOD_NS 40
`define BVW_WDOG_UNIT_NS 2000000
`define BVW_WDOG_UNIT_CYCLES (`BVW_WDOG_UNIT_NS / `BVW_CLK_PERIOD_NS)

`endif

// ---- rtl/bvw_sync3.v ----
// Purpose: three-stage synchroniser for asynchronous level inputs
// Assumes: inputs are slow levels such as straps and clock-present flags
// Notes: a change is accepted once the second and third stages agree
`timescale 1ns/10ps
`default_nettype none

module bvw_sync3 #(
	parameter N = 2
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// asynchronous levels in
	input wire [N-1:0] async_in,
	// filtered levels out
	output reg [N-1:0] level_q,
	output reg [N-1:0] valid_q
);

	reg [N-1:0] s1_q;
	reg [N-1:0] s2_q;
	reg [N-1:0] s3_q;
	reg [N-1:0] p1_q;
	reg [N-1:0] p2_q;
	reg [N-1:0] p3_q;

	// ****************************************
	// synchroniser stages
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < N; i = i + 1)
		begin : g_bit
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					s1_q[i] <= 1'b0;
					s2_q[i] <= 1'b0;
					s3_q[i] <= 1'b0;
					p1_q[i] <= 1'b0;
					p2_q[i] <= 1'b0;
					p3_q[i] <= 1'b0;
					level_q[i] <= 1'b0;
					valid_q[i] <= 1'b0;
				end
				else
				begin
					// first stage feeds the second stage only
					s1_q[i] <= async_in[i];
					s2_q[i] <= s1_q[i];
					s3_q[i] <= s2_q[i];
					// level_q waits until the primer chain has filled, so the stages hold pin samples, not reset zeros
					p1_q[i] <= 1'b1;
					p2_q[i] <= p1_q[i];
					p3_q[i] <= p2_q[i];
					if (p3_q[i] && s2_q[i] == s3_q[i])
					begin
						level_q[i] <= s3_q[i];
						valid_q[i] <= 1'b1;
					end
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// ---- rtl/bvw_regs.v ----
// Purpose: self-test control, pad voltage select and control channel watchdog registers
// Assumes: APB slave on pclk at 25 MHz, presetn is the power-up reset
// Notes: every output comes from a flip-flop
//
// Summary of operation
// RQ1: with self-test off, no TMDS clock and the config bit set, oscillator code 00/01 gives 50 MHz, 10 gives 100 MHz, 11 gives 25 MHz.
// RQ2: with self-test on, oscillator code 00 gives the external pixel clock, 01 gives 33 MHz and 1x gives 100 MHz.
// RQ3: bit 0 of the self-test register enables self-test, resets to off, and bits 7 to 3 read as zero.
// RQ4: at power-up the pad voltage select is loaded from the strap, low meaning 3.3V and high meaning 1.8V.
// RQ5: a digital reset returns the pad voltage select to 3.3V whatever the strap said.
// RQ6: reading the pad voltage register returns 0 for 1.8V and 1 for 3.3V, and it resets to 0x01.
// RQ7: the pad voltage select changes only on write code 0xb5, which sets it, or 0xb6, which clears it, also via fuse.
// RQ8: while enabled the watchdog ends any control channel transaction that outlasts the programmed timeout.
// RQ9: the seven-bit timeout field in bits 7 to 1 counts in 2 ms units and the register resets to 0xfe.
// RQ10: software should never program a timeout of zero and is advised to use one.
// RQ11: watchdog bit 0 at zero lets the watchdog run, at one stops it from ever ending a transaction.
// RQ12: the watchdog restarts at each transaction start, stops at completion, and on expiry aborts and goes idle.
`timescale 1ns/10ps
`default_nettype none
`include "bvw_consts.vh"

module bvw_regs #(
	parameter WDOG_UNIT_CYCLES = `BVW_WDOG_UNIT_CYCLES
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`BVW_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// straps and device state
	input wire sclk_strap_pin,
	input wire tmds_clk_present_pin,
	input wire cfg_osc_framing_en,
	input wire digital_reset,
	// fuse programming port
	input wire fuse_wr_valid,
	input wire [7:0] fuse_wr_data,
	// control channel transactions
	input wire cc_txn_start,
	input wire cc_txn_done,
	output reg cc_txn_abort,
	output reg cc_watchdog_busy,
	// block outputs
	output reg selftest_enable,
	output reg [2:0] framing_clk_sel,
	output reg pad_voltage_strap_select,
	output reg irq
);

	// ****************************************
	// declarations
	// ****************************************
	localparam WD_IDLE = 1'b0;
	localparam WD_RUN = 1'b1;
	localparam SEL_NONE = 3'h0;
	localparam SEL_ST = 3'h1;
	localparam SEL_PV = 3'h2;
	localparam SEL_WD = 3'h3;
	localparam SEL_IS = 3'h4;
	localparam SEL_IM = 3'h5;
	localparam integer UNIT_LAST_I = WDOG_UNIT_CYCLES - 1;
	localparam [31:0] UNIT_LAST_W = UNIT_LAST_I;
	localparam [15:0] UNIT_LAST = UNIT_LAST_W[15:0];
	localparam [7:0] ST_RST = `BVW_RST_SELFTEST;
	localparam [7:0] WD_RST = `BVW_RST_WDOG;
	reg [2:0] selftest_control_q, clk_sel_d, wr_sel, rd_sel;
	reg [6:0] wd_timeout_q, wd_units_q;
	reg wd_disable_q, strap_loaded_q, wd_state_q, vsel_reset_event;
	reg [`BVW_IRQ_W-1:0] irq_status_q, irq_mask_q;
	reg [15:0] wd_prescale_q;
	reg [7:0] rdata_d;
	wire [1:0] sync_level, sync_valid, osc_field;
	wire strap_level, tmds_present, wr_en, wd_expire;

	// ****************************************
	// address decode
	// ****************************************
	// shared by read and write paths, misaligned addresses map nowhere
	function [2:0] reg_select;
		input [`BVW_ADDR_W-1:0] addr;
		begin
			if (addr[1:0] != 2'b00)
				reg_select = SEL_NONE;
			else
			begin
				case (addr[`BVW_ADDR_W-1:2])
				`BVW_IDX_SELFTEST: reg_select = SEL_ST;
				`BVW_IDX_PADVSEL: reg_select = SEL_PV;
				`BVW_IDX_WDOG: reg_select = SEL_WD;
				`BVW_IDX_IRQ_STATUS: reg_select = SEL_IS;
				`BVW_IDX_IRQ_MASK: reg_select = SEL_IM;
				default: reg_select = SEL_NONE;
				endcase
			end
		end
	endfunction

	// ****************************************
	// asynchronous inputs
	// ****************************************
	bvw_sync3 #(.N(2)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({tmds_clk_present_pin, sclk_strap_pin}),
		.level_q(sync_level),
		.valid_q(sync_valid)
	);
	assign strap_level = sync_level[0];
	assign tmds_present = sync_level[1];
	assign osc_field = selftest_control_q[`BVW_ST_OSC_HI:`BVW_ST_OSC_LO];

	// ****************************************
	// apb slave
	// ****************************************
	// no wait state: read data is built in the setup cycle so prdata is a flop
	assign wr_en = psel & penable & pready & pwrite & ~pslverr;

	always @*
	begin
		rd_sel = reg_select(paddr);
		wr_sel = reg_select(paddr);
		case (rd_sel)
		SEL_ST: rdata_d = {5'h00, selftest_control_q}; // [RQ3]
		SEL_PV: rdata_d = {7'h00, pad_voltage_strap_select}; // [RQ6]
		SEL_WD: rdata_d = {wd_timeout_q, wd_disable_q};
		SEL_IS: rdata_d = {6'h00, irq_status_q};
		SEL_IM: rdata_d = {6'h00, irq_mask_q};
		default: rdata_d = 8'h00;
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else if (psel & ~penable)
		begin
			pready <= 1'b1;
			pslverr <= (rd_sel == SEL_NONE);
			prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rdata_d};
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// ****************************************
	// self-test control and watchdog control
	// ****************************************
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			selftest_control_q <= ST_RST[2:0]; // [RQ3]
			wd_timeout_q <= WD_RST[`BVW_WD_TMO_HI:`BVW_WD_TMO_LO]; // [RQ9]
			wd_disable_q <= 1'b0; // [RQ11]
			irq_mask_q <= {`BVW_IRQ_W{1'b0}};
		end
		else if (wr_en)
		begin
			if (wr_sel == SEL_ST)
				selftest_control_q <= pwdata[2:0]; // [RQ3]
			if (wr_sel == SEL_WD)
			begin
				wd_timeout_q <= pwdata[`BVW_WD_TMO_HI:`BVW_WD_TMO_LO]; // [RQ9]
				wd_disable_q <= pwdata[`BVW_WD_DIS_BIT]; // [RQ11]
			end
			if (wr_sel == SEL_IM)
				irq_mask_q <= pwdata[`BVW_IRQ_W-1:0];
		end
	end

	// ****************************************
	// pad voltage select
	// ****************************************
	// register value 1 means 3.3V, so the strap level is inverted on load
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pad_voltage_strap_select <= `BVW_RST_PADVSEL; // [RQ6]
			strap_loaded_q <= 1'b0;
			vsel_reset_event <= 1'b0;
		end
		else
		begin
			vsel_reset_event <= 1'b0;
			if (digital_reset)
			begin
				pad_voltage_strap_select <= 1'b1; // [RQ5]
				vsel_reset_event <= 1'b1;
			end
			else if (!strap_loaded_q && sync_valid[0])
			begin
				pad_voltage_strap_select <= ~strap_level; // [RQ4]
				strap_loaded_q <= 1'b1;
			end
			else if (wr_en && wr_sel == SEL_PV && (pwdata[7:0] == `BVW_VSEL_SET_CODE || pwdata[7:0] == `BVW_VSEL_CLR_CODE))
				pad_voltage_strap_select <= (pwdata[7:0] == `BVW_VSEL_SET_CODE); // [RQ7]
			else if (fuse_wr_valid && (fuse_wr_data == `BVW_VSEL_SET_CODE || fuse_wr_data == `BVW_VSEL_CLR_CODE))
				pad_voltage_strap_select <= (fuse_wr_data == `BVW_VSEL_SET_CODE); // [RQ7]
		end
	end
	// ****************************************
	// framing clock selection
	// ****************************************
	always @*
	begin
		if (selftest_control_q[`BVW_ST_EN_BIT])
			case (osc_field)
			2'b00: clk_sel_d = `BVW_CLK_EXTPIX; // [RQ2]
			2'b01: clk_sel_d = `BVW_CLK_OSC33; // [RQ2]
			default: clk_sel_d = `BVW_CLK_OSC100; // [RQ2]
			endcase
		else if (!tmds_present && cfg_osc_framing_en)
			case (osc_field)
			2'b10: clk_sel_d = `BVW_CLK_OSC100; // [RQ1]
			2'b11: clk_sel_d = `BVW_CLK_OSC25; // [RQ1]
			default: clk_sel_d = `BVW_CLK_OSC50; // [RQ1]
			endcase
		else
			clk_sel_d = `BVW_CLK_TMDS;
	end
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			framing_clk_sel <= `BVW_CLK_TMDS;
			selftest_enable <= 1'b0;
		end
		else
		begin
			framing_clk_sel <= clk_sel_d;
			selftest_enable <= selftest_control_q[`BVW_ST_EN_BIT]; // [RQ3]
		end
	end

	// ****************************************
	// control channel watchdog
	// ****************************************
	// a zero timeout expires after a single unit; start or done in that cycle wins over expiry
	assign wd_expire = (wd_state_q == WD_RUN) && !wd_disable_q && !cc_txn_start && !cc_txn_done
		&& (wd_prescale_q == UNIT_LAST) && (wd_units_q + 7'h01 >= wd_timeout_q); // [RQ8] [RQ9]
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wd_state_q <= WD_IDLE;
			wd_prescale_q <= 16'h0000;
			wd_units_q <= 7'h00;
			cc_txn_abort <= 1'b0;
			cc_watchdog_busy <= 1'b0;
		end
		else
		begin
			cc_txn_abort <= 1'b0;
			case (wd_state_q)
			WD_IDLE:
				if (cc_txn_start)
				begin
					wd_state_q <= WD_RUN; // [RQ12]
					wd_prescale_q <= 16'h0000;
					wd_units_q <= 7'h00;
					cc_watchdog_busy <= 1'b1;
				end
			WD_RUN:
			begin
				if (cc_txn_start)
				begin
					wd_prescale_q <= 16'h0000; // [RQ12]
					wd_units_q <= 7'h00;
				end
				else if (cc_txn_done)
				begin
					wd_state_q <= WD_IDLE; // [RQ12]
					cc_watchdog_busy <= 1'b0;
				end
				else if (wd_expire)
				begin
					wd_state_q <= WD_IDLE; // [RQ12]
					cc_txn_abort <= 1'b1; // [RQ8]
					cc_watchdog_busy <= 1'b0;
				end
				else if (!wd_disable_q) // [RQ11]
				begin
					if (wd_prescale_q == UNIT_LAST)
					begin
						wd_prescale_q <= 16'h0000;
						wd_units_q <= wd_units_q + 7'h01;
					end
					else
						wd_prescale_q <= wd_prescale_q + 16'h0001;
				end
			end
			default: wd_state_q <= WD_IDLE;
			endcase
		end
	end

	// ****************************************
	// interrupts
	// ****************************************
	// a new event beats a write-one-to-clear in the same cycle
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_status_q <= {`BVW_IRQ_W{1'b0}};
			irq <= 1'b0;
		end
		else
		begin
			irq_status_q <= (irq_status_q & ~((wr_en && wr_sel == SEL_IS) ? pwdata[`BVW_IRQ_W-1:0] : 2'b00))
				| {vsel_reset_event, wd_expire};
			irq <= |(irq_status_q & irq_mask_q);
		end
	end

endmodule

`default_nettype wire

// ---- verif/bvw_regs_sva.sv ----
// Purpose: concurrent checks on the bvw_regs ports
// Assumes: one clock, asynchronous active-low reset
// Notes: bound into every bvw_regs instance
`timescale 1ns/10ps
`default_nettype none
`include "bvw_consts.vh"

module bvw_regs_sva #(
	parameter WDOG_UNIT_CYCLES = 10
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`BVW_ADDR_W-1:0] paddr,
	input wire logic pready,
	// device side
	input wire logic digital_reset,
	input wire logic fuse_wr_valid,
	input wire logic [7:0] fuse_wr_data,
	input wire logic cc_txn_start,
	input wire logic cc_txn_abort,
	input wire logic cc_watchdog_busy,
	input wire logic selftest_enable,
	input wire logic [2:0] framing_clk_sel,
	input wire logic pad_voltage_strap_select
);
	// ****************************************
	// helpers
	// ****************************************
	logic pad_wr;
	logic fuse_cmd;
	assign pad_wr = psel && penable && pwrite && paddr == {`BVW_IDX_PADVSEL, 2'b00};
	// apb and reset win over the fuse, so only an uncontested fuse code is judged
	assign fuse_cmd = fuse_wr_valid && !digital_reset && !pad_wr
		&& fuse_wr_data inside {`BVW_VSEL_SET_CODE, `BVW_VSEL_CLR_CODE};
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	// timeout is at least one unit, so no abort for eight cycles after a start
	sequence s_quiet;
		!cc_txn_abort [*8];
	endsequence

	// ****************************************
	// assertions
	// ****************************************
	a_ready_after_setup: assert property (s_setup |=> pready) else $error("no ready after setup");
	a_ready_one_pulse: assert property (pready |=> !pready) else $error("ready held too long");
	a_dreset_pad_33v: assert property (digital_reset |=> pad_voltage_strap_select)
		else $error("digital reset left pad at 1.8V");
	a_fuse_write_code: assert property (fuse_cmd |=>
		pad_voltage_strap_select == ($past(fuse_wr_data) == `BVW_VSEL_SET_CODE))
		else $error("fuse code not applied");
	a_abort_one_pulse: assert property (cc_txn_abort |=> !cc_txn_abort) else $error("abort held");
	a_abort_goes_idle: assert property (cc_txn_abort |-> !cc_watchdog_busy) else $error("busy on abort");
	a_no_early_abort: assert property (cc_txn_start |=> s_quiet) else $error("abort before timeout");
	a_selftest_source: assert property (selftest_enable |->
		framing_clk_sel inside {`BVW_CLK_EXTPIX, `BVW_CLK_OSC33, `BVW_CLK_OSC100})
		else $error("bad self-test clock");
	a_func_source: assert property (!selftest_enable |->
		framing_clk_sel inside {`BVW_CLK_TMDS, `BVW_CLK_OSC50, `BVW_CLK_OSC100, `BVW_CLK_OSC25})
		else $error("bad functional clock");
endmodule

bind bvw_regs bvw_regs_sva #(.WDOG_UNIT_CYCLES(WDOG_UNIT_CYCLES)) chk_u (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pready, .digital_reset, .fuse_wr_valid, .fuse_wr_data, .cc_txn_start, .cc_txn_abort,
	.cc_watchdog_busy, .selftest_enable, .framing_clk_sel, .pad_voltage_strap_select);
`default_nettype wire

// ---- verif/testbench.sv ----
// Purpose: self-checking bench for bvw_regs
// Assumes: 25 MHz pclk, watchdog unit shortened to 10 cycles
// Notes: strap tied high, so the loaded select reads as 1.8V
`timescale 1ns/10ps
`default_nettype none
`include "bvw_consts.vh"

module testbench;
	localparam int UNIT = 10;
	typedef struct {logic w; logic [9:0] a; logic [7:0] d; logic [7:0] q; logic e;} bvw_row_t;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [9:0] paddr = 10'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr, cc_txn_abort, cc_watchdog_busy, selftest_enable, pad_voltage_strap_select, irq, er;
	logic [2:0] framing_clk_sel;
	logic sclk_strap_pin = 1'b1, tmds_clk_present_pin = 1'b0, cfg_osc_framing_en = 1'b1;
	logic digital_reset = 1'b0, fuse_wr_valid = 1'b0, cc_txn_start = 1'b0, cc_txn_done = 1'b0;
	logic [7:0] fuse_wr_data = 8'h00;
	int n_fail = 0, samples_checked = 0, cyc = 0, n;
	logic [2:0] clk_tab[8] = '{`BVW_CLK_OSC50, `BVW_CLK_OSC50, `BVW_CLK_OSC100, `BVW_CLK_OSC25,
		`BVW_CLK_EXTPIX, `BVW_CLK_OSC33, `BVW_CLK_OSC100, `BVW_CLK_OSC100};
	logic [8:0] fuse_tab[5] = '{9'h0b6, 9'h000, 9'h1b5, 9'h112, 9'h0b6};
	bvw_row_t rows[16] = '{
		'{1'b0, 10'h050, 8'h00, 8'h00, 1'b0},
		'{1'b0, 10'h054, 8'h00, 8'h00, 1'b0},
		'{1'b0, 10'h058, 8'h00, 8'hfe, 1'b0},
		'{1'b0, 10'h084, 8'h00, 8'h00, 1'b0},
		'{1'b1, 10'h050, 8'hff, 8'h00, 1'b0},
		'{1'b0, 10'h050, 8'h00, 8'h07, 1'b0},
		'{1'b1, 10'h054, 8'h12, 8'h00, 1'b0},
		'{1'b0, 10'h054, 8'h00, 8'h00, 1'b0},
		'{1'b1, 10'h054, 8'hb5, 8'h00, 1'b0},
		'{1'b0, 10'h054, 8'h00, 8'h01, 1'b0},
		'{1'b1, 10'h054, 8'hb6, 8'h00, 1'b0},
		'{1'b0, 10'h054, 8'h00, 8'h00, 1'b0},
		'{1'b1, 10'h058, 8'ha4, 8'h00, 1'b0},
		'{1'b0, 10'h058, 8'h00, 8'ha4, 1'b0},
		'{1'b0, 10'h03c, 8'h00, 8'h00, 1'b1},
		'{1'b1, 10'h052, 8'h00, 8'h00, 1'b1}};

	bvw_regs #(.WDOG_UNIT_CYCLES(UNIT)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .sclk_strap_pin, .tmds_clk_present_pin, .cfg_osc_framing_en,
		.digital_reset, .fuse_wr_valid, .fuse_wr_data, .cc_txn_start, .cc_txn_done, .cc_txn_abort,
		.cc_watchdog_busy, .selftest_enable, .framing_clk_sel, .pad_voltage_strap_select, .irq);

	// ****************************************
	// clock, timeout and tasks
	// ****************************************
	always #20 pclk = ~pclk;
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			n_fail++;
			end_sim();
		end
	end

	task end_sim;
		$display("checks=%0d mismatches=%0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// no wait count is assumed, the cycle ceiling ends a lost transfer
	task apb(input logic w, input logic [9:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task pulse_dreset;
		@(posedge pclk);
		digital_reset <= 1'b1;
		@(posedge pclk);
		digital_reset <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask

	task wd(input logic [7:0] cfg, input int done_at, input int exp);
		apb(1'b1, 10'h058, cfg);
		@(posedge pclk);
		cc_txn_start <= 1'b1;
		@(posedge pclk);
		cc_txn_start <= 1'b0;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
			cc_txn_done <= (n == done_at);
			if (n == 1)
				chk(cc_watchdog_busy, 1'b1);
		end
		while (cc_txn_abort !== 1'b1 && n < 45);
		chk((cc_txn_abort === 1'b1) ? n : 0, exp);
		chk(cc_watchdog_busy, exp == 0 && done_at == 0);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
		foreach (rows[i])
		begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			chk(rd, {24'h00_0000, rows[i].q});
			chk(er, rows[i].e);
		end
		for (int c = 0; c < 8; c++)
		begin
			apb(1'b1, 10'h050, {5'h00, c[1:0], c[2]});
			repeat (2) @(posedge pclk);
			chk(framing_clk_sel, clk_tab[c]);
			chk(selftest_enable, c[2]);
		end
		apb(1'b1, 10'h050, 8'h06);
		tmds_clk_present_pin <= 1'b1;
		repeat (8) @(posedge pclk);
		chk(framing_clk_sel, `BVW_CLK_TMDS);
		tmds_clk_present_pin <= 1'b0;
		cfg_osc_framing_en <= 1'b0;
		repeat (8) @(posedge pclk);
		chk(framing_clk_sel, `BVW_CLK_TMDS);
		cfg_osc_framing_en <= 1'b1;
		repeat (2) @(posedge pclk);
		chk(framing_clk_sel, `BVW_CLK_OSC25);
		apb(1'b1, 10'h084, 8'h03);
		pulse_dreset();
		chk({irq, pad_voltage_strap_select}, 2'b11);
		apb(1'b0, 10'h080, 8'h00);
		chk(rd, 32'h0000_0002);
		apb(1'b1, 10'h080, 8'h02);
		apb(1'b1, 10'h084, 8'h00);
		pulse_dreset();
		apb(1'b1, 10'h084, 8'h01);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b0);
		foreach (fuse_tab[i])
		begin
			@(posedge pclk);
			fuse_wr_valid <= 1'b1;
			fuse_wr_data <= fuse_tab[i][7:0];
			@(posedge pclk);
			fuse_wr_valid <= 1'b0;
			repeat (2) @(posedge pclk);
			chk(pad_voltage_strap_select, fuse_tab[i][8]);
		end
		wd(8'h03, 0, 0);
		wd(8'h02, 3, 0);
		wd(8'h02, 0, UNIT + 1);
		wd(8'h04, 0, 2 * UNIT + 1);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b1);
		apb(1'b0, 10'h080, 8'h00);
		chk(rd, 32'h0000_0003);
		end_sim();
	end
endmodule
`default_nettype wire
